// ===== smr_defs.vh
/*
 * Constants for the serial message recognizer: sizes, reset values and
 * timing figures. Included by smr_recognizer.v only.
 */
`ifndef SMR_DEFS_VH
`define SMR_DEFS_VH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define SMR_VIEW_BYTES     12
`define SMR_PEND_BYTES     128
`define SMR_TERM_BYTES     8
`define SMR_TERM_DIGITS    16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SMR_CLK_MHZ        40
`define SMR_TICK_US        1000
`define SMR_IDLE_MIN_MS    16'h000a
`define SMR_IDLE_OFF_MS    16'h0000

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SMR_HOLD_RST_MS    8'h32

`endif

// ===== smr_properties.sv
/* Port assertions for smr_recognizer.
   Assumes one clock and the asynchronous active-high reset. */
`timescale 1ns/1ps
module smr_properties (
  // Control
  input logic        sys_clk_i,
  input logic        rst_i,
  input logic        framing_on_i,
  input logic        clear_i,
  input logic        hold_time_wr_i,
  input logic [7:0]  hold_time_data_i,
  input logic [7:0]  linked_action_number_i,
  // Views and status
  input logic [95:0] last_message_text_o,
  input logic [3:0]  last_message_len_o,
  input logic        last_changed_o,
  input logic [3:0]  transient_len_o,
  input logic        transient_changed_o,
  input logic [7:0]  transient_hold_time_o,
  input logic        action_fire_o,
  input logic [7:0]  action_number_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_hold_rst; $fell(rst_i) |-> transient_hold_time_o == 8'h32;
  endproperty
  a_hold_rst: assert property (p_hold_rst)
    else $error("hold time wrong after reset");
  property p_pair; (action_fire_o == transient_changed_o) &&
    (!last_changed_o || action_fire_o); endproperty
  a_pair: assert property (p_pair)
    else $error("commit pulses disagree");
  property p_act; action_fire_o |->
    action_number_o == $past(linked_action_number_i); endproperty
  a_act: assert property (p_act)
    else $error("action number wrong");
  property p_keep; !action_fire_o && !$past(clear_i) |->
    $stable(last_message_text_o); endproperty
  a_keep: assert property (p_keep)
    else $error("last text moved without cause");
  property p_clear; clear_i |=> action_fire_o ||
    (last_message_len_o == 4'h0 && transient_len_o == 4'h0); endproperty
  a_clear: assert property (p_clear)
    else $error("clear left a view");
  property p_chg; action_fire_o |-> last_changed_o ==
    (last_message_text_o != $past(last_message_text_o) ||
     last_message_len_o != $past(last_message_len_o)); endproperty
  a_chg: assert property (p_chg)
    else $error("last change pulse wrong");
  property p_off; !framing_on_i |=> !action_fire_o; endproperty
  a_off: assert property (p_off)
    else $error("commit while framing off");
  property p_wr; hold_time_wr_i |=>
    transient_hold_time_o == $past(hold_time_data_i); endproperty
  a_wr: assert property (p_wr)
    else $error("hold time not loaded");
endmodule
bind smr_recognizer smr_properties u_props (.sys_clk_i, .rst_i,
  .framing_on_i, .clear_i, .hold_time_wr_i, .hold_time_data_i,
  .linked_action_number_i, .last_message_text_o, .last_message_len_o,
  .last_changed_o, .transient_len_o, .transient_changed_o,
  .transient_hold_time_o, .action_fire_o, .action_number_o);

// ===== smr_recognizer.v
/*
 * Serial message recognizer: frames received bytes into messages ended by
 * a terminator sequence or an idle gap, keeps last and transient views.
 * Assumes bytes arrive as one-cycle strobes synchronous to sys_clk_i and
 * that the control ports are static or pulsed by a management host.
 */
// Notes on behaviour
// - Idle gap expiry without terminator commits pending bytes as a message.
// - Idle gap in ms; zero disables it, nonzero below ten acts as ten.
// - Terminator match or idle gap expiry completes a message.
// - Last text view stays until next message or clear.
// - Text views hold at most twelve bytes.
// - Hex views give two ASCII hex digits per held byte.
// - Clear empties every held message view, unless a message commits in the same cycle.
// - Transient text, hex and digest load per message, cleared after hold time.
// - Hold time resets to fifty milliseconds.
// - Hold time is an eight-bit millisecond setting, 0 to 255.
// - Last view signals change only when content differs.
// - Transient view signals change on every message.
// - Each message fires the linked action number.
// - Terminator is up to eight bytes, given as sixteen hex digits.
// - Up to 128 unrecognized bytes are kept pending.
// - Recognition runs only while framing is on.
`timescale 1ns/1ps
`include "smr_defs.vh"

module smr_recognizer #(
  parameter TICK_CYCLES = `SMR_CLK_MHZ * `SMR_TICK_US
) (
  // Clock and reset
  input  wire         sys_clk_i,
  input  wire         rst_i,
  // Receive byte stream
  input  wire         rx_valid_i,
  input  wire [7:0]   rx_byte_i,
  // Configuration
  input  wire         framing_on_i,
  input  wire [15:0]  idle_gap_ms_i,
  input  wire [63:0]  message_terminator_bytes_i,
  input  wire [3:0]   terminator_len_i,
  input  wire         hold_time_wr_i,
  input  wire [7:0]   hold_time_data_i,
  input  wire [7:0]   linked_action_number_i,
  input  wire         clear_i,
  // Last message views
  output reg  [95:0]  last_message_text_o,
  output reg  [191:0] last_message_hexview_o,
  output reg  [3:0]   last_message_len_o,
  output reg          last_changed_o,
  // Transient views
  output reg  [95:0]  transient_message_text_o,
  output reg  [191:0] transient_message_hexview_o,
  output reg  [15:0]  transient_message_digest_o,
  output reg  [3:0]   transient_len_o,
  output reg          transient_changed_o,
  // Status and action
  output reg  [7:0]   transient_hold_time_o,
  output reg  [7:0]   pending_count_o,
  output reg          action_fire_o,
  output reg  [7:0]   action_number_o
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function [7:0] smr_hex_char;
    input [3:0] nib;
    begin
      if (nib < 4'ha)
        smr_hex_char = 8'h30 + {4'h0, nib};
      else
        smr_hex_char = 8'h37 + {4'h0, nib};
    end
  endfunction

  // Byte i of text sits at [8i+7:8i]; its two digits at [16i+15:16i]
  function [191:0] smr_hexview;
    input [95:0] txt;
    input [3:0]  len;
    integer k;
    begin
      smr_hexview = 192'h0;
      for (k = 0; k < `SMR_VIEW_BYTES; k = k + 1) begin
        if (k < len) begin
          smr_hexview[16*k+8 +: 8] = smr_hex_char(txt[8*k+4 +: 4]);
          smr_hexview[16*k   +: 8] = smr_hex_char(txt[8*k   +: 4]);
        end
      end
    end
  endfunction

  // Rotate-xor digest; cheap, not cryptographic
  function [15:0] smr_digest;
    input [95:0] txt;
    input [3:0]  len;
    integer k;
    begin
      smr_digest = {12'h000, len};
      for (k = 0; k < `SMR_VIEW_BYTES; k = k + 1) begin
        if (k < len)
          smr_digest = {smr_digest[10:0], smr_digest[15:11]}
                       ^ {8'h00, txt[8*k +: 8]};
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------
  reg  [15:0] tick_cnt_r;
  reg         ms_tick_r;

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= 16'h0000;
      ms_tick_r  <= 1'b0;
    end else if (tick_cnt_r == TICK_CYCLES[15:0] - 16'h0001) begin
      tick_cnt_r <= 16'h0000;
      ms_tick_r  <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      ms_tick_r  <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Pending store and terminator match
  // --------------------------------------------------------------------
  reg  [7:0]  pend_mem [0:`SMR_PEND_BYTES-1];
  reg  [63:0] hist_r;
  reg  [15:0] idle_ms_r;
  reg  [7:0]  hold_ms_r;
  reg         hold_run_r;

  wire        byte_in   = rx_valid_i & framing_on_i;
  wire [63:0] hist_nxt  = {hist_r[55:0], rx_byte_i};
  reg  [63:0] term_mask;
  reg  [8:0]  seen_cnt;
  reg         term_hit;
  reg  [15:0] idle_lim;
  reg         idle_hit;
  reg  [8:0]  msg_raw;
  reg  [3:0]  msg_len;
  reg  [95:0] msg_text;
  reg         commit;
  integer     i;

  always @* begin
    term_mask = 64'h0;
    for (i = 0; i < `SMR_TERM_BYTES; i = i + 1)
      if (i < terminator_len_i)
        term_mask[8*i +: 8] = 8'hff;
    seen_cnt = {1'b0, pending_count_o} + 9'h001;
    // Match only bytes of this message, on each arrival
    term_hit = byte_in && (terminator_len_i != 4'h0)
               && (terminator_len_i <= 4'h8)
               && (seen_cnt >= {5'h00, terminator_len_i})
               && ((hist_nxt & term_mask)
                   == (message_terminator_bytes_i & term_mask));
    // Below-minimum settings act as the minimum
    idle_lim = (idle_gap_ms_i < `SMR_IDLE_MIN_MS) ? `SMR_IDLE_MIN_MS
                                                  : idle_gap_ms_i;
    idle_hit = framing_on_i && !byte_in
               && (idle_gap_ms_i != `SMR_IDLE_OFF_MS)
               && (pending_count_o != 8'h00)
               && (idle_ms_r >= idle_lim);
    commit = term_hit | idle_hit;
    // Terminator bytes are stripped from the message
    msg_raw = term_hit ? seen_cnt - {5'h00, terminator_len_i}
                       : {1'b0, pending_count_o};
    if (msg_raw > `SMR_VIEW_BYTES)
      msg_len = 4'hc;
    else
      msg_len = msg_raw[3:0];
    msg_text = 96'h0;
    for (i = 0; i < `SMR_VIEW_BYTES; i = i + 1)
      if (i < msg_len)
        msg_text[8*i +: 8] = pend_mem[i];
  end

  always @(posedge sys_clk_i) begin
    if (byte_in && !term_hit && pending_count_o < `SMR_PEND_BYTES)
      pend_mem[pending_count_o[6:0]] <= rx_byte_i;
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_count_o <= 8'h00;
      hist_r          <= 64'h0;
      idle_ms_r       <= 16'h0000;
    end else if (commit) begin
      pending_count_o <= 8'h00;
      hist_r          <= 64'h0;
      idle_ms_r       <= 16'h0000;
    end else if (byte_in) begin
      hist_r    <= hist_nxt;
      idle_ms_r <= 16'h0000;
      // Full store drops further bytes
      if (pending_count_o < `SMR_PEND_BYTES)
        pending_count_o <= pending_count_o + 8'h01;
    end else if (ms_tick_r && pending_count_o != 8'h00
                 && idle_ms_r != 16'hffff) begin
      idle_ms_r <= idle_ms_r + 16'h0001;
    end
  end

  // --------------------------------------------------------------------
  // Hold time setting
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      transient_hold_time_o <= `SMR_HOLD_RST_MS;
    else if (hold_time_wr_i)
      transient_hold_time_o <= hold_time_data_i;
  end

  // --------------------------------------------------------------------
  // Message views
  // --------------------------------------------------------------------
  wire last_differs = (msg_text != last_message_text_o)
                      || (msg_len != last_message_len_o);

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_message_text_o         <= 96'h0;
      last_message_hexview_o      <= 192'h0;
      last_message_len_o          <= 4'h0;
      last_changed_o              <= 1'b0;
      transient_message_text_o    <= 96'h0;
      transient_message_hexview_o <= 192'h0;
      transient_message_digest_o  <= 16'h0000;
      transient_len_o             <= 4'h0;
      transient_changed_o         <= 1'b0;
      hold_ms_r                   <= 8'h00;
      hold_run_r                  <= 1'b0;
      action_fire_o               <= 1'b0;
      action_number_o             <= 8'h00;
    end else begin
      last_changed_o      <= 1'b0;
      transient_changed_o <= 1'b0;
      action_fire_o       <= 1'b0;
      // A commit in the clear cycle wins over the clear
      if (commit) begin
        last_message_text_o    <= msg_text;
        last_message_hexview_o <= smr_hexview(msg_text, msg_len);
        last_message_len_o     <= msg_len;
        last_changed_o         <= last_differs;
        transient_message_text_o    <= msg_text;
        transient_message_hexview_o <= smr_hexview(msg_text, msg_len);
        transient_message_digest_o  <= smr_digest(msg_text, msg_len);
        transient_len_o             <= msg_len;
        transient_changed_o         <= 1'b1;
        hold_ms_r                   <= 8'h00;
        hold_run_r                  <= 1'b1;
        action_fire_o               <= 1'b1;
        action_number_o             <= linked_action_number_i;
      end else if (clear_i ||
                   (hold_run_r && hold_ms_r >= transient_hold_time_o)) begin
        // Clear empties both; hold expiry only the transient set
        if (clear_i) begin
          last_message_text_o    <= 96'h0;
          last_message_hexview_o <= 192'h0;
          last_message_len_o     <= 4'h0;
        end
        transient_message_text_o    <= 96'h0;
        transient_message_hexview_o <= 192'h0;
        transient_message_digest_o  <= 16'h0000;
        transient_len_o             <= 4'h0;
        hold_run_r                  <= 1'b0;
        hold_ms_r                   <= 8'h00;
      end else if (hold_run_r && ms_tick_r) begin
        hold_ms_r <= hold_ms_r + 8'h01;
      end
    end
  end

endmodule

// ===== smr_recognizer_unused_guard.v
/*
 * Holds no logic: the whole recognizer lives in smr_recognizer.v.
 * Assumes nothing of its surroundings.
 */

// ===== smr_serial_dev.sv
/* Far-side serial source: hands received bytes to the recognizer.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module smr_serial_dev (
  // Clock
  input  wire logic  sys_clk_i,
  // Byte stream
  output logic       rx_valid_o,
  output logic [7:0] rx_byte_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'hff;
  end
  // Back-to-back bytes: strobe stays high between calls
  task send_byte(input logic [7:0] b);
    @(posedge sys_clk_i);
    #1 rx_valid_o = 1'b1;
    rx_byte_o = b;
  endtask
  // Idle line shows the inverse so stale data never looks valid
  task release_line;
    @(posedge sys_clk_i);
    #1 rx_valid_o = 1'b0;
    rx_byte_o = ~rx_byte_o;
  endtask
endmodule

// ===== smr_tb.sv
/* Self-checking bench for smr_recognizer with a serial source model.
   Assumes a 40 MHz clock and a shortened millisecond tick. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
  end end
module testbench;
  localparam int T = 20;
  logic sys_clk_i, rst_i, framing_on_i, hold_time_wr_i, clear_i, rx_valid_i;
  logic last_changed_o, transient_changed_o, action_fire_o;
  logic [3:0] terminator_len_i, last_message_len_o, transient_len_o;
  logic [7:0] hold_time_data_i, linked_action_number_i, rx_byte_i;
  logic [7:0] transient_hold_time_o, pending_count_o, action_number_o;
  logic [15:0] idle_gap_ms_i, transient_message_digest_o;
  logic [63:0] message_terminator_bytes_i;
  logic [95:0] last_message_text_o, transient_message_text_o, pe;
  logic [191:0] last_message_hexview_o, transient_message_hexview_o;
  logic [7:0] q[$];
  logic [3:0] pl;
  int n_mismatch = 0, total_checks = 0, k;
  smr_recognizer #(.TICK_CYCLES(T)) dut (.sys_clk_i, .rst_i, .rx_valid_i,
    .rx_byte_i, .framing_on_i, .idle_gap_ms_i, .message_terminator_bytes_i,
    .terminator_len_i, .hold_time_wr_i, .hold_time_data_i,
    .linked_action_number_i, .clear_i, .last_message_text_o,
    .last_message_hexview_o, .last_message_len_o, .last_changed_o,
    .transient_message_text_o, .transient_message_hexview_o,
    .transient_message_digest_o, .transient_len_o, .transient_changed_o,
    .transient_hold_time_o, .pending_count_o, .action_fire_o,
    .action_number_o);
  smr_serial_dev u_dev (.sys_clk_i, .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [7:0] hx(input logic [3:0] v);
    return v < 4'ha ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  // Digest model: start from the length, rotate left by 5, xor each byte
  function automatic logic [15:0] dg(input logic [95:0] t, input int n);
    logic [15:0] d;
    d = 16'(n);
    for (int i = 0; i < n; i++)
      d = ((d << 5) | (d >> 11)) ^ {8'h00, t[8*i+:8]};
    return d;
  endfunction
  task automatic put(input int cnt);
    logic [7:0] b;
    repeat (cnt) begin
      b = 8'h20 + 8'($urandom % 95);
      if (q.size() < 128) q.push_back(b);
      u_dev.send_byte(b);
    end
  endtask
  // Reference model: first twelve bytes of the message, terminator gone
  task automatic commit(output int w);
    logic [95:0] et;
    logic [191:0] eh;
    logic [3:0] el;
    et = '0;
    eh = '0;
    w = 0;
    el = 4'(q.size() > 12 ? 12 : q.size());
    for (int i = 0; i < el; i++) begin
      et[8*i+:8] = q[i];
      eh[16*i+:16] = {hx(q[i][7:4]), hx(q[i][3:0])};
    end
    while (action_fire_o !== 1'b1 && w < 400) begin
      @(posedge sys_clk_i);
      #1 w++;
    end
    `CHK(w < 400, 1'b1)
    if (w == 400) end_of_test;
    `CHK({last_message_len_o, last_message_text_o}, {el, et})
    `CHK(last_message_hexview_o, eh)
    `CHK(transient_message_text_o, et)
    `CHK(transient_len_o, el)
    `CHK(transient_message_hexview_o, eh)
    `CHK(transient_message_digest_o, dg(et, el))
    `CHK(last_changed_o, (et !== pe) || (el !== pl))
    `CHK(transient_changed_o, 1'b1)
    `CHK(action_number_o, linked_action_number_i)
    pe = et;
    pl = el;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    framing_on_i = 1'b1;
    idle_gap_ms_i = 16'h0000;
    clear_i = 1'b0;
    message_terminator_bytes_i = 64'h0d0a;
    terminator_len_i = 4'h2;
    hold_time_wr_i = 1'b0;
    hold_time_data_i = 8'h00;
    linked_action_number_i = 8'h00;
    pe = '0;
    pl = 4'h0;
    void'($urandom(66));
    repeat (16) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    `CHK(transient_hold_time_o, 8'h32)
    for (int i = 0; i < 2; i++) begin
      hold_time_data_i = i ? 8'h03 : 8'hff;
      hold_time_wr_i = 1'b1;
      @(posedge sys_clk_i);
      #1 hold_time_wr_i = 1'b0;
      `CHK(transient_hold_time_o, hold_time_data_i)
    end
    // Last pass repeats the previous message unchanged
    for (int m = 0; m < 4; m++) begin
      linked_action_number_i = 8'($urandom);
      if (m < 3) q.delete();
      if (m < 3) put(1 + $urandom % 14);
      else foreach (q[i]) u_dev.send_byte(q[i]);
      u_dev.send_byte(8'h0d);
      u_dev.send_byte(8'h0a);
      u_dev.release_line();
      commit(k);
      if (m == 0) begin
        repeat (2 * T - 4) @(posedge sys_clk_i);
        #1 `CHK(transient_len_o == pl, 1'b1)
        repeat (2 * T + 8) @(posedge sys_clk_i);
        #1 `CHK({transient_len_o, transient_message_digest_o}, 20'h0)
        `CHK(last_message_text_o, pe)
      end
    end
    clear_i = 1'b1;
    @(posedge sys_clk_i);
    #1 clear_i = 1'b0;
    `CHK({last_message_len_o, last_message_hexview_o}, 196'h0)
    `CHK({last_message_text_o, transient_message_text_o}, 192'h0)
    pe = '0;
    pl = 4'h0;
    framing_on_i = 1'b0;
    u_dev.send_byte(8'h41);
    u_dev.send_byte(8'h0d);
    u_dev.send_byte(8'h0a);
    u_dev.release_line();
    `CHK({pending_count_o, last_message_len_o}, 12'h000)
    framing_on_i = 1'b1;
    q.delete();
    put(20);
    u_dev.release_line();
    repeat (15 * T) @(posedge sys_clk_i);
    #1 `CHK(pending_count_o, 8'h14)
    put(120);
    u_dev.release_line();
    `CHK(pending_count_o, 8'h80)
    idle_gap_ms_i = 16'h0005;
    commit(k);
    `CHK(k >= 9 * T && k <= 11 * T + 4, 1'b1)
    // Eight-byte terminator above the printable range, never in the data
    terminator_len_i = 4'h8;
    message_terminator_bytes_i = {$urandom, $urandom} | 64'h8080808080808080;
    q.delete();
    put(5);
    for (int i = 7; i >= 0; i--)
      u_dev.send_byte(message_terminator_bytes_i[8*i+:8]);
    u_dev.release_line();
    commit(k);
    `CHK(k, 0)
    end_of_test;
  end
endmodule
